// >>> rtl/dmcfg_pkg.sv
package dmcfg_pkg;
    localparam logic [7:0] ADDR_MODE_EN = 8'h53;
    localparam logic [7:0] ADDR_FILT_MERGE = 8'h54;
    localparam logic [7:0] ADDR_DATA_CTRL = 8'h55;
    localparam logic [7:0] ADDR_BAT_HIGH = 8'h56;
    localparam logic [7:0] ADDR_BAT_LOW = 8'h57;

    localparam logic [7:0] RST_MODE_EN = 8'h00;
    localparam logic [7:0] RST_FILT_MERGE = 8'h48;
    localparam logic [7:0] RST_DATA_CTRL = 8'h00;

    // writable bits; all others are reserved and read as zero
    localparam logic [7:0] MASK_MODE_EN = 8'hFE;
    localparam logic [7:0] MASK_FILT_MERGE = 8'h6D;
    localparam logic [7:0] MASK_DATA_CTRL = 8'h03;

    localparam int BIT_MANUAL = 7;
    localparam int BIT_EN_LOAD = 6;
    localparam int BIT_EN_MICBIAS = 5;
    localparam int BIT_EN_BATTERY = 4;
    localparam int BIT_EN_TEMP = 3;
    localparam int BIT_EN_SUPPLY = 2;
    localparam int BIT_EN_AUX = 1;
    localparam int POS_SUPPLY_FILT = 5;
    localparam int POS_BATTERY_FILT = 2;
    localparam int BIT_MERGE = 0;
    localparam int BIT_OVERRIDE = 1;
    localparam int BIT_FREEZE = 0;

    localparam logic [3:0] CHAN_BATTERY = 4'h0;
    localparam int RESULT_W = 12;
    localparam logic [RESULT_W-1:0] RST_RESULT = 12'h000;

    typedef struct packed {
        logic [7:0] mode_en;
        logic [7:0] filt_merge;
        logic [7:0] data_ctrl;
        logic [7:0] rdata;
        logic en_battery;
        logic en_micbias;
        logic en_load;
        logic en_temp;
        logic ovp_fault;
        logic bat_short_fault;
    } dmcfg_state_t;
endpackage

// >>> rtl/dmcfg_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - auto mode enables four monitors with inputs
// - bit 6 enables load channel in manual
// - bit 5 enables mic-bias channel in manual
// - bit 4 enables battery channel in manual
// - bit 3 enables temperature channel in manual
// - bit 2 enables supply channel always
// - bit 1 enables aux analog channel always
// - merge bit ORs overvoltage into battery short
// - bit 1 enables battery/thermal data override
// - freeze bit stops result register updates
// - battery high byte read-only at 0x56
// - low nibble plus channel id 0000b
module dmcfg_regs #(
    parameter int RESULT_W = 12
) (
    input wire logic clk, // core clock
    input wire logic rstn, // async reset, active low
    input wire logic [7:0] reg_addr, // register address
    input wire logic reg_wr, // write strobe
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, one cycle after reg_rd
    input wire logic input_diag_any, // some input diagnostic enabled
    input wire logic sample_valid, // converter result strobe
    input wire logic [3:0] sample_chan, // converter result channel
    input wire logic [RESULT_W-1:0] sample_data, // converter result
    input wire logic [RESULT_W-1:0] override_data, // override result
    input wire logic in_overvoltage, // raw input overvoltage
    input wire logic in_short_battery, // raw input short to battery
    output logic battery_check_on, // battery monitor enable
    output logic micbias_check_on, // mic-bias voltage monitor enable
    output logic micbias_load_check_on, // mic-bias load monitor enable
    output logic temp_check_on, // temperature monitor enable
    output logic analog_supply_check_on, // supply monitor enable
    output logic aux_analog_check_on, // aux analog monitor enable
    output logic [1:0] supply_filter_choice, // supply filter select
    output logic [1:0] battery_filter_choice, // battery filter select
    output logic battery_thermal_data_override, // override enable
    output logic freeze_monitor_result, // result hold active
    output logic fault_overvoltage, // reported overvoltage fault
    output logic fault_battery_short // reported battery short fault
);
    dmcfg_pkg::dmcfg_state_t s_q;
    dmcfg_pkg::dmcfg_state_t s_d;

    dmcfg_store_if #(.W(RESULT_W)) bat_if ();

    dmcfg_result_store #(.W(RESULT_W)) u_bat_store (
        .clk(clk),
        .rstn(rstn),
        .st(bat_if.store)
    );

    function automatic logic [7:0] masked_write(input logic [7:0] wdata,
                                                input logic [7:0] mask,
                                                input logic [7:0] rstv);
        masked_write = (wdata & mask) | (rstv & ~mask);
    endfunction

    // one-hot select shared by the write and the read decode, so the
    // two paths can never disagree about which register is addressed
    typedef struct packed {
        logic mode_en;
        logic filt_merge;
        logic data_ctrl;
        logic bat_high;
        logic bat_low;
    } dmcfg_sel_t;

    function automatic dmcfg_sel_t decode_addr(input logic [7:0] a);
        decode_addr = '0;
        if (a == dmcfg_pkg::ADDR_MODE_EN) begin
            decode_addr.mode_en = 1'b1;
        end else if (a == dmcfg_pkg::ADDR_FILT_MERGE) begin
            decode_addr.filt_merge = 1'b1;
        end else if (a == dmcfg_pkg::ADDR_DATA_CTRL) begin
            decode_addr.data_ctrl = 1'b1;
        end else if (a == dmcfg_pkg::ADDR_BAT_HIGH) begin
            decode_addr.bat_high = 1'b1;
        end else if (a == dmcfg_pkg::ADDR_BAT_LOW) begin
            decode_addr.bat_low = 1'b1;
        end
    endfunction

    // a monitor follows its own bit in manual mode, the inputs otherwise
    function automatic logic pick_enable(input logic manual_mode,
                                         input logic own_bit,
                                         input logic auto_on);
        pick_enable = manual_mode ? own_bit : auto_on;
    endfunction

    // both filter fields are two bits wide, only their position differs
    function automatic logic [1:0] filter_field(input logic [7:0] r,
                                                input int pos);
        filter_field = r[pos +: 2];
    endfunction

    // the result is read as a high byte and a low nibble with its channel
    function automatic logic [7:0] result_byte(input logic [RESULT_W-1:0] r,
                                               input logic high);
        if (high) begin
            result_byte = r[RESULT_W-1 -: 8];
        end else begin
            result_byte = {r[3:0], dmcfg_pkg::CHAN_BATTERY};
        end
    endfunction

    logic manual;
    logic freeze;
    logic override_on;
    dmcfg_sel_t sel;

    always_comb begin
        manual = s_q.mode_en[dmcfg_pkg::BIT_MANUAL];
        freeze = s_q.data_ctrl[dmcfg_pkg::BIT_FREEZE];
        override_on = s_q.data_ctrl[dmcfg_pkg::BIT_OVERRIDE];
        sel = decode_addr(reg_addr);
    end

    // updates stop while frozen so the high and low reads match
    // the freeze holds off the override too, so a held pair stays put
    always_comb begin
        bat_if.load = 1'b0;
        bat_if.wdata = sample_data;
        if (!freeze) begin
            if (override_on) begin
                bat_if.load = 1'b1;
                bat_if.wdata = override_data;
            end else if (sample_valid &&
                         sample_chan == dmcfg_pkg::CHAN_BATTERY) begin
                bat_if.load = 1'b1;
            end
        end
    end

    always_comb begin
        s_d = s_q;
        // reserved bits are forced to their reset value on write
        if (reg_wr) begin
            if (sel.mode_en) begin
                s_d.mode_en = masked_write(reg_wdata,
                    dmcfg_pkg::MASK_MODE_EN, dmcfg_pkg::RST_MODE_EN);
            end else if (sel.filt_merge) begin
                s_d.filt_merge = masked_write(reg_wdata,
                    dmcfg_pkg::MASK_FILT_MERGE, dmcfg_pkg::RST_FILT_MERGE);
            end else if (sel.data_ctrl) begin
                s_d.data_ctrl = masked_write(reg_wdata,
                    dmcfg_pkg::MASK_DATA_CTRL, dmcfg_pkg::RST_DATA_CTRL);
            end
        end

        // unmapped reads give zero; read data stands until the next read
        if (reg_rd) begin
            if (sel.mode_en) begin
                s_d.rdata = s_q.mode_en;
            end else if (sel.filt_merge) begin
                s_d.rdata = s_q.filt_merge;
            end else if (sel.data_ctrl) begin
                s_d.rdata = s_q.data_ctrl;
            end else if (sel.bat_high) begin
                s_d.rdata = result_byte(bat_if.rdata, 1'b1);
            end else if (sel.bat_low) begin
                s_d.rdata = result_byte(bat_if.rdata, 1'b0);
            end else begin
                s_d.rdata = 8'h00;
            end
        end

        // auto mode ties the four channels to the input diagnostics
        s_d.en_load = pick_enable(manual,
            s_q.mode_en[dmcfg_pkg::BIT_EN_LOAD], input_diag_any);
        s_d.en_micbias = pick_enable(manual,
            s_q.mode_en[dmcfg_pkg::BIT_EN_MICBIAS], input_diag_any);
        s_d.en_battery = pick_enable(manual,
            s_q.mode_en[dmcfg_pkg::BIT_EN_BATTERY], input_diag_any);
        s_d.en_temp = pick_enable(manual,
            s_q.mode_en[dmcfg_pkg::BIT_EN_TEMP], input_diag_any);

        // merged mode leaves the overvoltage output quiet
        if (s_q.filt_merge[dmcfg_pkg::BIT_MERGE]) begin
            s_d.ovp_fault = 1'b0;
            s_d.bat_short_fault = in_overvoltage | in_short_battery;
        end else begin
            s_d.ovp_fault = in_overvoltage;
            s_d.bat_short_fault = in_short_battery;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{mode_en: dmcfg_pkg::RST_MODE_EN,
                     filt_merge: dmcfg_pkg::RST_FILT_MERGE,
                     data_ctrl: dmcfg_pkg::RST_DATA_CTRL,
                     default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        reg_rdata = s_q.rdata;
        battery_check_on = s_q.en_battery;
        micbias_check_on = s_q.en_micbias;
        micbias_load_check_on = s_q.en_load;
        temp_check_on = s_q.en_temp;
        analog_supply_check_on = s_q.mode_en[dmcfg_pkg::BIT_EN_SUPPLY];
        aux_analog_check_on = s_q.mode_en[dmcfg_pkg::BIT_EN_AUX];
        supply_filter_choice = filter_field(s_q.filt_merge,
            dmcfg_pkg::POS_SUPPLY_FILT);
        battery_filter_choice = filter_field(s_q.filt_merge,
            dmcfg_pkg::POS_BATTERY_FILT);
        battery_thermal_data_override = override_on;
        freeze_monitor_result = freeze;
        fault_overvoltage = s_q.ovp_fault;
        fault_battery_short = s_q.bat_short_fault;
    end
endmodule

// >>> rtl/dmcfg_result_store.sv
`timescale 1ns/1ps
module dmcfg_result_store #(
    parameter int W = 12
) (
    input wire logic clk, // core clock
    input wire logic rstn, // async reset, active low
    dmcfg_store_if.store st // load port and registered read data
);
    logic [W-1:0] data_q;
    logic [W-1:0] data_d;

    // both halves live in one word so a freeze keeps them coherent
    always_comb begin
        data_d = data_q;
        if (st.load) begin
            data_d = st.wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_q <= W'(dmcfg_pkg::RST_RESULT);
        end else begin
            data_q <= data_d;
        end
    end

    assign st.rdata = data_q;
endmodule

// >>> rtl/dmcfg_store_if.sv
`timescale 1ns/1ps
interface dmcfg_store_if #(
    parameter int W = 12
);
    logic load;
    logic [W-1:0] wdata;
    logic [W-1:0] rdata;

    modport writer (output load, output wdata, input rdata);
    modport store (input load, input wdata, output rdata);
endinterface

// >>> tb/dmcfg_host.sv
`timescale 1ns/1ps
module dmcfg_host (
    input wire logic clk, // core clock
    input wire logic [7:0] reg_rdata, // read data
    output logic [7:0] reg_addr = 8'h00, // address
    output logic reg_wr = 1'b0, // write strobe
    output logic [7:0] reg_wdata = 8'h00, // write data
    output logic reg_rd = 1'b0 // read strobe
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d & (a == 8'h53 ? 8'hFE : a == 8'h54 ? 8'h6D :
            a == 8'h55 ? 8'h03 : 8'hFF);
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        // idle data is scrambled so a stale value is never trusted
        reg_wdata = ~reg_wdata;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
endmodule

// >>> tb/dmcfg_regs_bench.sv
`timescale 1ns/1ps
module dmcfg_regs_bench;
    logic clk = 1'b0, rstn = 1'b0, input_diag_any = 1'b0, sample_valid = 1'b0;
    logic in_overvoltage = 1'b0, in_short_battery = 1'b0, reg_wr, reg_rd;
    logic [3:0] sample_chan = 4'h0;
    logic [11:0] sample_data = 12'h000, override_data = 12'h000, v;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, r;
    logic battery_check_on, micbias_check_on, micbias_load_check_on;
    logic temp_check_on, analog_supply_check_on, aux_analog_check_on;
    logic [1:0] supply_filter_choice, battery_filter_choice;
    logic battery_thermal_data_override, freeze_monitor_result;
    logic fault_overvoltage, fault_battery_short;
    integer seed = 32'h192e, fails = 0, check_count = 0, cyc = 0, i;
    logic [7:0] rst_tab [6] = '{8'h00, 8'h48, 8'h00, 8'h00, 8'h00, 8'h00};
    always #2 clk = ~clk;
    dmcfg_host dmcfg_host_i (.*);
    dmcfg_regs dmcfg_regs_i (.*);
    function automatic logic [7:0] exp_en(input logic [7:0] m, input logic g);
        return {4'h0, m[7] ? m[6:3] : {4{g}}};
    endfunction
    function automatic logic [7:0] exp_flt(input logic m, o, s);
        return {6'h00, o & !m, s | (o & m)};
    endfunction
    task check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        if (fails == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task samp(input logic [3:0] c, input logic [11:0] x);
        sample_chan = c;
        sample_data = x;
        sample_valid = 1'b1;
        @(posedge clk);
        #1;
        sample_valid = 1'b0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        dmcfg_host_i.rd(a, r);
        check(r, exp);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            give_verdict;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        #1 rstn = 1'b1;
        for (i = 0; i < 6; i++)
            rd_chk(i < 5 ? 8'h53 + 8'(i) : 8'h40, rst_tab[i]);
        for (i = 0; i < 40; i++) begin
            d = 8'($random(seed));
            input_diag_any = d[1];
            in_overvoltage = d[4];
            in_short_battery = d[7];
            dmcfg_host_i.wr(8'h53, d);
            dmcfg_host_i.wr(8'h54, d);
            rd_chk(8'h53, d & 8'hFE);
            rd_chk(8'h54, d & 8'h6D);
            check({4'h0, micbias_load_check_on, micbias_check_on,
                battery_check_on, temp_check_on}, exp_en(d, d[1]));
            check({6'h00, analog_supply_check_on, aux_analog_check_on},
                {6'h00, d[2:1]});
            check({4'h0, supply_filter_choice, battery_filter_choice},
                {4'h0, d[6:5], d[3:2]});
            check({6'h00, fault_overvoltage, fault_battery_short},
                exp_flt(d[0], d[4], d[7]));
            v = 12'($random(seed));
            samp(4'h0, v);
            samp(4'h3, ~v);
            dmcfg_host_i.wr(8'h55, 8'h01);
            samp(4'h0, ~v);
            rd_chk(8'h56, v[11:4]);
            rd_chk(8'h57, {v[3:0], 4'h0});
            dmcfg_host_i.wr(8'h55, 8'h02);
            override_data = ~v;
            dmcfg_host_i.wr(8'h56, v[7:0]);
            rd_chk(8'h56, ~v[11:4]);
            dmcfg_host_i.wr(8'h55, 8'h00);
        end
        give_verdict;
    end
endmodule

// >>> tb/dmcfg_regs_checker.sv
`timescale 1ns/1ps
module dmcfg_regs_checker (
    input wire logic clk, // core clock
    input wire logic rstn, // async reset, active low
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [7:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic [7:0] reg_rdata, // read data
    input wire logic input_diag_any, // input diagnostics on
    input wire logic in_overvoltage, // raw overvoltage
    input wire logic in_short_battery, // raw short
    input wire logic battery_check_on, // battery monitor
    input wire logic micbias_check_on, // mic-bias monitor
    input wire logic micbias_load_check_on, // load monitor
    input wire logic temp_check_on, // temperature monitor
    input wire logic analog_supply_check_on, // supply monitor
    input wire logic aux_analog_check_on, // aux monitor
    input wire logic [1:0] supply_filter_choice, // supply filter
    input wire logic [1:0] battery_filter_choice, // battery filter
    input wire logic battery_thermal_data_override, // override
    input wire logic freeze_monitor_result, // hold
    input wire logic fault_overvoltage, // overvoltage fault
    input wire logic fault_battery_short // short fault
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence wr_at(logic [7:0] a);
        reg_wr && reg_addr == a;
    endsequence
    sequence auto_wr;
        wr_at(8'h53) ##0 !reg_wdata[7] ##1 !reg_wr;
    endsequence
    sequence manual_wr;
        wr_at(8'h53) ##0 reg_wdata[7];
    endsequence
    direct_en_a: assert property (wr_at(8'h53) |=>
        {analog_supply_check_on, aux_analog_check_on} == $past(reg_wdata[2:1]))
        else $error("direct enables differ");
    manual_en_a: assert property (manual_wr |-> ##2
        {micbias_load_check_on, micbias_check_on, battery_check_on,
        temp_check_on} == $past(reg_wdata[6:3], 2))
        else $error("manual enables differ");
    auto_en_a: assert property (auto_wr |-> ##1
        battery_check_on == $past(input_diag_any) &&
        temp_check_on == $past(input_diag_any))
        else $error("auto enables differ");
    filter_sel_a: assert property (wr_at(8'h54) |=>
        supply_filter_choice == $past(reg_wdata[6:5]) &&
        battery_filter_choice == $past(reg_wdata[3:2]))
        else $error("filter choice differs");
    data_ctrl_a: assert property (wr_at(8'h55) |=>
        {battery_thermal_data_override, freeze_monitor_result}
        == $past(reg_wdata[1:0])) else $error("data control differs");
    ov_fault_a: assert property (
        fault_overvoltage |-> $past(in_overvoltage))
        else $error("overvoltage without cause");
    short_fault_a: assert property (
        $past(rstn) && !$past(in_overvoltage) |->
        fault_battery_short == $past(in_short_battery))
        else $error("short fault differs");
    rsvd_read_a: assert property (reg_rd && reg_addr == 8'h55 |=>
        reg_rdata[7:2] == 6'h00) else $error("reserved bits set");
    chan_id_a: assert property (reg_rd && reg_addr == 8'h57 |=>
        reg_rdata[3:0] == 4'h0) else $error("channel id wrong");
endmodule
bind dmcfg_regs dmcfg_regs_checker dmcfg_regs_checker_i (.*);
